// file: rtl/vdo_pkg.sv
// Package with the types and constants of the video output timing block.
package vdo_pkg;
   // Sampling standards, each with its own line length.
   typedef enum logic [2:0] {
      VDO_NTSC_601, VDO_NTSC_SQ, VDO_NTSC_4FSC, VDO_PAL_601, VDO_PAL_SQ
   } vdo_std_t;
   // Correction modes: two line-buffer modes and the frame-store mode.
   typedef enum logic [1:0] {VDO_LB1, VDO_LB2, VDO_FRAME} vdo_buf_t;
   // One output pixel with its aligned timing marks.
   typedef struct packed {
      logic [7:0] data;
      logic blank;
      logic hsync_n;
      logic vsync_n;
      logic line_active_window;
      logic vertical_active_window;
      logic field_odd;
      logic flag_a;
      logic flag_b;
   } vdo_word_t;
   localparam int HW = 10; // Pixel counter width.
   localparam int VW = 9; // Line counter width.
   // Total and active pixels per line for each standard.
   localparam logic [HW-1:0] TOT_N601 = 10'd858;
   localparam logic [HW-1:0] TOT_NSQ = 10'd780;
   localparam logic [HW-1:0] TOT_N4F = 10'd910;
   localparam logic [HW-1:0] TOT_P601 = 10'd864;
   localparam logic [HW-1:0] TOT_PSQ = 10'd944;
   localparam logic [HW-1:0] ACT_601 = 10'd720;
   localparam logic [HW-1:0] ACT_NSQ = 10'd640;
   localparam logic [HW-1:0] ACT_768 = 10'd768;
   // Lines per field and blank lines per field, odd then even.
   localparam logic [VW-1:0] NTSC_VTOT_ODD = 9'd263;
   localparam logic [VW-1:0] NTSC_VTOT_EVEN = 9'd262;
   localparam logic [VW-1:0] NTSC_VBLK = 9'd20;
   localparam logic [VW-1:0] PAL_VTOT_ODD = 9'd312;
   localparam logic [VW-1:0] PAL_VTOT_EVEN = 9'd313;
   localparam logic [VW-1:0] PAL_VBLK_ODD = 9'd23;
   localparam logic [VW-1:0] PAL_VBLK_EVEN = 9'd24;
   // Sync pulse lengths; plain defaults.
   localparam logic [HW-1:0] HSYNC_PIX = 10'd64;
   localparam logic [VW-1:0] VSYNC_LINES = 9'd3;
   // Timing reference code bytes.
   localparam logic [7:0] TRC_FF = 8'hff;
   localparam logic [7:0] TRC_00 = 8'h00;
   localparam logic [HW-1:0] TRC_LEN = 10'd4;
endpackage

// file: rtl/vdo_out_timing.sv
// Output timing of the video decoder: counters, latency line and output buffer.
`timescale 1ns/1ps
module vdo_out_timing #(
   parameter int DEPTH = 2048 // Delay line words; must hold 1.5 of the longest line.
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] in_data,
   input wire logic in_valid,
   input wire logic in_sol,
   output logic in_ready,
   input wire vdo_pkg::vdo_std_t video_std,
   input wire vdo_pkg::vdo_buf_t buffer_mode,
   input wire logic trap_filter,
   input wire logic async_fixed_clock,
   input wire logic degraded_source,
   input wire logic embedded_sync,
   input wire logic [1:0] flag_select,
   input wire logic out_ready,
   output logic out_valid,
   output vdo_pkg::vdo_word_t out_word
);
   import vdo_pkg::*;
   localparam int AW = $clog2(DEPTH);
   // Longest latency: one and a half of the longest line.
   localparam int LAT_MAX = int'(TOT_PSQ) + int'(TOT_PSQ) / 2;

   // The pointers wrap at a power of two, so the depth must be one, and hold the longest latency.
   if (DEPTH != (1 << AW) || DEPTH < LAT_MAX) begin : g_depth_bad
      $error("DEPTH must be a power of two that holds the longest latency");
   end

   logic tick_q; // Pixel enable from the divide-by-two.
   logic [HW-1:0] h_q; // Pixel position in the line.
   logic [VW-1:0] v_q; // Line position in the field.
   logic field_q; // High in the odd field.
   logic vs_plan_q; // Vertical sync planned for the next line.
   logic va_plan_q; // Vertical window planned for the next line.
   logic vs_cur_q; // Vertical sync of the current line.
   logic va_cur_q; // Vertical window of the current line.
   logic [AW-1:0] wr_q; // Delay line write pointer.
   logic [AW:0] fill_q; // Words written since reset, saturating.
   logic primed_q; // Delay line holds a full latency.
   logic push_q; // A delayed word is ready to enter the buffer.
   vdo_word_t rd_q; // Word read from the delay line.
   vdo_word_t skid_q; // Second buffer entry.
   logic skid_valid_q; // Second entry is occupied.
   vdo_word_t mem [DEPTH]; // The latency line itself.
   logic [HW-1:0] htot, hact, hblk;
   logic [VW-1:0] vtot, vblk;
   logic [AW-1:0] lat;
   logic adv, line_end, reset_line, is_pal;
   vdo_word_t stamp;

   // Line geometry of the chosen standard.
   always_comb begin
      is_pal = (video_std == VDO_PAL_601) || (video_std == VDO_PAL_SQ);
      unique case (video_std)
         VDO_NTSC_601: begin htot = TOT_N601; hact = ACT_601; end
         VDO_NTSC_SQ: begin htot = TOT_NSQ; hact = ACT_NSQ; end
         VDO_NTSC_4FSC: begin htot = TOT_N4F; hact = ACT_768; end
         VDO_PAL_601: begin htot = TOT_P601; hact = ACT_601; end
         VDO_PAL_SQ: begin htot = TOT_PSQ; hact = ACT_768; end
         default: begin htot = TOT_N601; hact = ACT_601; end
      endcase
      hblk = htot - hact;
      if (is_pal) begin
         vtot = field_q ? PAL_VTOT_ODD : PAL_VTOT_EVEN;
         vblk = field_q ? PAL_VBLK_ODD : PAL_VBLK_EVEN;
      end else begin
         vtot = field_q ? NTSC_VTOT_ODD : NTSC_VTOT_EVEN;
         vblk = NTSC_VBLK;
      end
      // The trap filter in PAL needs no comb line, so only half a line remains.
      if (is_pal && trap_filter) begin
         lat = AW'(htot >> 1);
      end else begin
         lat = AW'(htot) + AW'(htot >> 1);
      end
   end

   // The pipeline moves only on an accepted word; in_ready already carries the pixel
   // tick and the room check, so moving at any other time would take a word upstream never saw go.
   assign adv = in_valid && in_ready;
   // The correction line follows the window fall, or precedes it on a bad source in the second line-buffer mode.
   assign reset_line = (buffer_mode != VDO_FRAME) && async_fixed_clock &&
      ((buffer_mode == VDO_LB2 && degraded_source) ? (v_q == vtot - 9'd1)
                                                     : (v_q == '0));
   // On the correction line the input line start ends the line, so its count differs.
   assign line_end = (h_q == htot - 10'd1) || (reset_line && in_sol && h_q != '0);

   // Divide the double-rate clock down to the pixel rate.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= !tick_q;
      end
   end

   // Pixel and line counters restart at reset release and run on accepted words.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         h_q <= '0;
         v_q <= '0;
         field_q <= 1'b1;
      end else if (adv) begin
         if (line_end) begin
            h_q <= '0;
            if (v_q == vtot - 9'd1) begin
               v_q <= '0;
               field_q <= !field_q;
            end else begin
               v_q <= v_q + 9'd1;
            end
         end else begin
            h_q <= h_q + 10'd1;
         end
      end
   end

   // Vertical state is worked out a line early and applied at the line start.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         vs_plan_q <= 1'b1;
         va_plan_q <= 1'b0;
         vs_cur_q <= 1'b1;
         va_cur_q <= 1'b0;
      end else if (adv) begin
         if (h_q == '0) begin
            vs_plan_q <= (v_q == vtot - 9'd1) || (v_q + 9'd1 < VSYNC_LINES);
            va_plan_q <= (v_q + 9'd1 >= vblk) && (v_q != vtot - 9'd1);
         end
         if (line_end) begin
            vs_cur_q <= vs_plan_q;
            va_cur_q <= va_plan_q;
         end
      end
   end

   // Stamp each input pixel with its timing, so one delay carries everything.
   always_comb begin
      stamp.line_active_window = (h_q >= hblk);
      stamp.vertical_active_window = va_cur_q;
      stamp.field_odd = field_q;
      stamp.blank = !(stamp.line_active_window && va_cur_q);
      stamp.hsync_n = (h_q >= HSYNC_PIX);
      stamp.vsync_n = !vs_cur_q;
      stamp.data = stamp.blank ? TRC_00 : in_data;
      if (embedded_sync) begin
         // Four words before active and four after carry the reference codes.
         if (h_q >= hblk - TRC_LEN && h_q < hblk) begin
            stamp.data = trc(h_q - (hblk - TRC_LEN), 1'b0);
         end else if (h_q < TRC_LEN) begin
            stamp.data = trc(h_q, 1'b1);
         end
      end
      unique case (flag_select)
         2'd0: begin stamp.flag_a = stamp.line_active_window; stamp.flag_b = va_cur_q; end
         2'd1: begin stamp.flag_a = field_q; stamp.flag_b = va_cur_q; end
         2'd2: begin stamp.flag_a = stamp.line_active_window; stamp.flag_b = field_q; end
         2'd3: begin stamp.flag_a = !stamp.blank; stamp.flag_b = field_q; end
      endcase
   end

   // Reference code word: three preamble bytes, one of ones and two of zeros, then the status byte.
   function automatic logic [7:0] trc(input logic [HW-1:0] idx, input logic eav);
      logic f, v;
      f = !field_q;
      v = !va_cur_q;
      unique case (idx[1:0])
         2'd0: trc = TRC_FF;
         2'd1, 2'd2: trc = TRC_00;
         2'd3: trc = {1'b1, f, v, eav, v ^ eav, f ^ eav, f ^ v, f ^ v ^ eav};
      endcase
   endfunction

   // The delay line: latency is the write pointer distance, identical for all fields.
   // In the line-buffer modes the correction line changes length at the counters and
   // the output carries that short line, so input-to-output latency stays lat words.
   always_ff @(posedge ref_clk) begin
      if (adv) begin
         mem[wr_q] <= stamp;
         rd_q <= mem[wr_q - lat];
      end
   end

   // Pointer and priming; nothing leaves before a full latency has entered.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         fill_q <= '0;
         primed_q <= 1'b0;
         push_q <= 1'b0;
      end else begin
         push_q <= adv && primed_q;
         if (adv) begin
            wr_q <= wr_q + 1'b1;
            if (!fill_q[AW]) begin
               fill_q <= fill_q + 1'b1;
            end
            if (fill_q >= {1'b0, lat}) begin
               primed_q <= 1'b1;
            end
         end
      end
   end

   // Two-entry output buffer; a receiver stall fills the second entry, then holds in_ready low.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_word <= '0;
         skid_valid_q <= 1'b0;
         skid_q <= '0;
         in_ready <= 1'b0;
      end else begin
         in_ready <= !tick_q && !skid_valid_q && !(push_q && out_valid && !out_ready);
         if (!out_valid || out_ready) begin
            if (skid_valid_q) begin
               out_word <= skid_q;
               out_valid <= 1'b1;
               skid_valid_q <= push_q;
               skid_q <= rd_q;
            end else begin
               out_word <= rd_q;
               out_valid <= push_q;
            end
         end else if (push_q) begin
            skid_q <= rd_q;
            skid_valid_q <= 1'b1;
         end
      end
   end

   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   tick_alternate_a: assert property ($past(rst_n) |-> tick_q != $past(tick_q))
      else $error("pixel tick did not alternate");
   line_wrap_a: assert property (adv && h_q == htot - 10'd1 |=> h_q == '0)
      else $error("line did not wrap at its total");
   line_range_a: assert property (h_q < htot)
      else $error("pixel counter beyond line total");
   latency_a: assert property (lat == (is_pal && trap_filter ? AW'(htot >> 1)
      : AW'(htot + (htot >> 1))))
      else $error("latency differs from the mode figure");
   trap_half_a: assert property (is_pal && trap_filter |-> lat < AW'(htot))
      else $error("trap filter latency still holds a line");
   vsync_early_a: assert property (adv && line_end && v_q == vtot - 9'd1
      |=> vs_cur_q)
      else $error("vertical sync not planned a line ahead");
   no_early_out_a: assert property (push_q |-> fill_q > ({1'b0, lat} + 1'b1))
      else $error("output before latency filled");
   hold_stall_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
      else $error("stalled word changed or vanished");
   code_status_a: assert property (embedded_sync && h_q == hblk - 10'd1
      |-> stamp.data[7] && !stamp.data[4])
      else $error("start code status byte wrong");
   flag_route_a: assert property (flag_select == 2'd1 |-> stamp.flag_a == field_q)
      else $error("flag pin not carrying field parity");
   corr_line_a: assert property (adv && reset_line && in_sol && h_q != '0 |=> h_q == '0)
      else $error("correction line did not restart");

   stall_fill_c: cover property (skid_valid_q && out_valid && !out_ready);
   field_wrap_c: cover property (adv && line_end && v_q == vtot - 9'd1);
   embedded_c: cover property (embedded_sync && push_q);
   short_line_c: cover property (adv && reset_line && in_sol && h_q != '0);
endmodule

// file: dv/vdo_sink.sv
// Downstream capture model that takes words promptly or with stalls.
`timescale 1ns/1ps
module vdo_sink (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic out_valid,
   input wire vdo_pkg::vdo_word_t out_word,
   output logic out_ready,
   output logic pop_q,
   output vdo_pkg::vdo_word_t word_q
);
   import vdo_pkg::*;
   logic [1:0] phase_q = 2'h0; // Stall pattern phase.
   // Ready moves off the sampling edge; slow mode is ready one cycle in three to fill the buffer.
   always @(negedge ref_clk) begin
      phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
      out_ready <= !slow || (phase_q == 2'h0);
   end
   // Each word taken is handed to the bench for exactly one cycle.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pop_q <= 1'b0;
         word_q <= '0;
      end else begin
         pop_q <= out_valid && out_ready;
         word_q <= out_word;
      end
   end
endmodule

// file: dv/vdo_out_timing_bench.sv
// Self-checking bench for the video output timing block.
`timescale 1ns/1ps
module vdo_out_timing_bench;
   import vdo_pkg::*;
   logic ref_clk = 1'b0; // Double-rate sample clock.
   logic rst_n = 1'b0; // Active-low reset.
   logic [7:0] in_data = 8'h00; // Stamped input byte.
   logic in_valid = 1'b1; // Upstream always offers a word.
   logic in_sol = 1'b0;
   logic in_ready;
   vdo_std_t video_std = VDO_NTSC_601;
   vdo_buf_t buffer_mode = VDO_LB1;
   logic trap_filter = 1'b0;
   logic async_fixed_clock = 1'b0;
   logic degraded_source = 1'b0;
   logic embedded_sync = 1'b0;
   logic [1:0] flag_select = 2'h0;
   logic out_ready, out_valid, slow = 1'b0, pop_q, ready_prev = 1'b0;
   vdo_word_t out_word, word_q;
   logic [15:0] acc = 16'h0; // Accepted input words since reset.
   int miscompares = 0;
   int comparisons = 0;
   int cyc = 0;
   vdo_out_timing DUT (.ref_clk(ref_clk), .rst_n(rst_n), .in_data(in_data),
      .in_valid(in_valid), .in_sol(in_sol), .in_ready(in_ready), .video_std(video_std),
      .buffer_mode(buffer_mode), .trap_filter(trap_filter),
      .async_fixed_clock(async_fixed_clock), .degraded_source(degraded_source),
      .embedded_sync(embedded_sync), .flag_select(flag_select), .out_ready(out_ready),
      .out_valid(out_valid), .out_word(out_word));
   vdo_sink sink (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .out_valid(out_valid),
      .out_word(out_word), .out_ready(out_ready), .pop_q(pop_q), .word_q(word_q));
   // Clock at 40 MHz.
   initial forever #12.5 ref_clk = ~ref_clk;
   // Reports a mismatch at once and counts every comparison.
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      comparisons++;
      if (seen !== want) begin
         miscompares++;
         $display("wrong value at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Counts accepts, watches the accept spacing and cuts a hang short.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         miscompares++;
         tally_and_finish;
      end
      if (rst_n && in_ready) check({15'h0, ready_prev}, 16'h0);
      ready_prev <= in_ready;
      acc <= !rst_n ? 16'h0 : acc + (in_valid && in_ready);
   end
   // The stamp follows the low byte of the accept count, so it repeats every 256 words.
   always @(negedge ref_clk) in_data <= acc[7:0];
   task automatic next_word(output vdo_word_t w);
      do @(negedge ref_clk); while (pop_q !== 1'b1);
      w = word_q;
   endtask
   // Resets with a setup, checks the fill latency, then measures one whole output line.
   task automatic run(input vdo_std_t s, input vdo_buf_t m, input logic trap,
         input logic emb, input logic [1:0] fs, input logic sl, input logic [1:0] cor,
         input logic [15:0] tot, input logic [15:0] act);
      logic [15:0] lat, n, a, k;
      logic prev, fa, fb;
      vdo_word_t w;
      lat = trap ? tot / 2 : tot + tot / 2;
      rst_n = 1'b0;
      video_std = s;
      buffer_mode = m;
      trap_filter = trap;
      embedded_sync = emb;
      flag_select = fs;
      slow = sl;
      // Bit 0 selects fixed-clock sampling, bit 1 a degraded source; start marks stay high with fixed-clock sampling.
      async_fixed_clock = cor[0];
      degraded_source = cor[1];
      in_sol = cor[0];
      repeat (2) @(negedge ref_clk);
      check({14'h0, out_valid, in_ready}, 16'h0);
      rst_n = 1'b1;
      // The first word is offered one cycle after the second accept that follows a full latency.
      do @(negedge ref_clk); while (out_valid !== 1'b1);
      check(acc, lat + 16'd2);
      next_word(w);
      k = 16'h0;
      prev = 1'b0;
      do begin
         k++;
         prev = w.hsync_n;
         next_word(w);
      end while (!(prev && !w.hsync_n));
      // Only a line-buffer correction line 0 is cut short, after its second pixel.
      check(k, (cor == 2'h1 && m != VDO_FRAME) ? tot + 16'd1 : tot - 16'd1);
      check({8'h0, w.data}, emb ? 16'h00ff : 16'h0);
      n = 16'h0;
      a = 16'h0;
      do begin
         n++;
         a += w.line_active_window;
         if (n == 16'h2) check({8'h0, w.data}, 16'h0);
         fa = (fs == 2'h1) ? w.field_odd : w.line_active_window;
         if (fs == 2'h3) fa = w.line_active_window & w.vertical_active_window;
         fb = fs[1] ? w.field_odd : w.vertical_active_window;
         check({14'h0, w.flag_a, w.flag_b}, {14'h0, fa, fb});
         check({15'h0, w.blank},
            {15'h0, !(w.line_active_window && w.vertical_active_window)});
         // The measured line lies within the first three lines, all under vertical sync.
         check({15'h0, w.vsync_n}, 16'h0);
         prev = w.hsync_n;
         next_word(w);
      end while (!(prev && !w.hsync_n));
      check(n, tot);
      check(a, act);
   endtask
   initial begin
      // The first run's own two reset cycles complete the eight-cycle reset.
      repeat (6) @(negedge ref_clk);
      // Every standard at least once, every flag routing and every correction mode.
      run(VDO_NTSC_601, VDO_LB1, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 16'd858, 16'd720);
      // Frame store has no correction line even with fixed-clock sampling.
      run(VDO_NTSC_SQ, VDO_FRAME, 1'b0, 1'b0, 2'h1, 1'b0, 2'h1, 16'd780, 16'd640);
      // A degraded source moves the correction line away from line 0.
      run(VDO_NTSC_4FSC, VDO_LB2, 1'b0, 1'b0, 2'h2, 1'b0, 2'h3, 16'd910, 16'd768);
      run(VDO_PAL_601, VDO_FRAME, 1'b0, 1'b0, 2'h3, 1'b0, 2'h0, 16'd864, 16'd720);
      // Trap filter shortens the latency by one line.
      run(VDO_PAL_SQ, VDO_LB1, 1'b1, 1'b0, 2'h0, 1'b0, 2'h0, 16'd944, 16'd768);
      // Embedded codes open the line.
      run(VDO_NTSC_601, VDO_LB1, 1'b0, 1'b1, 2'h0, 1'b0, 2'h0, 16'd858, 16'd720);
      // Fixed-clock sampling in line-buffer mode cuts the correction line short.
      run(VDO_NTSC_601, VDO_LB1, 1'b0, 1'b0, 2'h3, 1'b0, 2'h1, 16'd858, 16'd720);
      // A stalling receiver fills the buffer and must lose no word.
      run(VDO_PAL_601, VDO_LB2, 1'b0, 1'b0, 2'h2, 1'b1, 2'h0, 16'd864, 16'd720);
      tally_and_finish;
   end
endmodule
